// >>> pkg/delay_config_pkg.sv
// Register map, field layout and shared types for the delay settings block
package delay_config_pkg;

  // Register addresses as seen through the serial pointer
  localparam logic [7:0] REG_CONTROL = 8'h01;
  localparam logic [7:0] REG_RIGHT_UP = 8'h02;
  localparam logic [7:0] REG_RIGHT_LO = 8'h03;
  localparam logic [7:0] REG_LEFT_UP = 8'h04;
  localparam logic [7:0] REG_LEFT_LO = 8'h05;
  localparam logic [7:0] REG_FRAME = 8'h06;
  localparam logic [7:0] REG_RJ_LEN = 8'h07;
  localparam logic [7:0] REG_COMMIT = 8'h08;

  // Reset value of every register
  localparam logic [7:0] REG_RESET = 8'h00;

  // Field positions and masks
  localparam int CTRL_MUTE_RIGHT_BIT = 7;
  localparam int CTRL_MUTE_LEFT_BIT = 6;
  localparam int COMMIT_BIT = 0;
  localparam int FRAME_SEL_BIT = 7;
  localparam int DELAY_W = 13;
  localparam logic [7:0] DELAY_UPPER_MASK = 8'h1f;
  localparam logic [7:0] RJ_LEN_MASK = 8'h3f;
  localparam logic [5:0] RJ_LEN_MAX = 6'h18;

  // Serial protocol constants
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [3:0] DEV_ADDR_HI_DEFAULT = 4'h5; // Arbitrary value

  // Settings as handed to the delay datapath
  typedef struct packed {
    logic [1:0] fmt;
    logic frame_sel;
    logic [7:0] frame;
    logic [DELAY_W-1:0] delay_r;
    logic [DELAY_W-1:0] delay_l;
    logic [5:0] rj_len;
  } settings_t;

  // Serial slave states
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_PTR,
    ST_PTR_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RD_BIT,
    ST_RD_ACK
  } serial_state_t;

endpackage

// >>> rtl/fill_mute.sv
`timescale 1ns/1ps
// Per-channel mute hold while a freshly committed delay line fills
module fill_mute #(
  parameter int W = 13
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Load from a commit
  input wire logic load,
  input wire logic [W-1:0] depth,
  // One pulse per audio sample of this channel
  input wire logic sample_tick,
  // Channel still filling
  output logic filling
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic filling;
  } fill_state_t;

  fill_state_t s_q;
  fill_state_t s_d;

  // Load wins over a coincident sample so the new depth is counted whole
  always_comb begin
    s_d = s_q;
    if (load) begin
      s_d.cnt = depth;
      s_d.filling = (depth != '0);
    end else if (sample_tick && s_q.filling) begin
      s_d.cnt = s_q.cnt - W'(1);
      if (s_q.cnt == W'(1)) begin
        s_d.filling = 1'b0;
      end
    end
  end

  // State register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign filling = s_q.filling;

endmodule

// >>> rtl/delay_config_commit.sv
`timescale 1ns/1ps
// Serial register file with commit transfer and fill-time muting
//
// Summary of operation
// - Writing one to commit bit zero copies staged settings to the datapath.
// - Commit write with bit zero clear transfers nothing; upper bits ignored.
// - Format, both delays or frame delay, and packet length move together.
// - After commit each channel stays muted until its delay in samples passed.
// - Control mute bits reach the outputs at once, no commit needed.
// - With frame delay selected the sample delay registers are disregarded.
// - Sequential read runs from control register through commit register.
// - Control bits seven and six select right and left channel mute.
// - Each sample delay is 13 bits across upper and lower registers.
// - Frame register top bit selects frame-based delay.
module delay_config_commit
  import delay_config_pkg::*;
#(
  parameter logic [3:0] DEV_ADDR_HI = DEV_ADDR_HI_DEFAULT // arbitrary value
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Serial control bus, data line open drain
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Address select straps, low bits of device address
  input wire logic [2:0] addr_sel,
  // Audio sample strobes and frame delay from the delay arithmetic
  input wire logic sample_tick_left,
  input wire logic sample_tick_right,
  input wire logic [DELAY_W-1:0] frame_delay_samples,
  // Datapath side
  output delay_config_pkg::settings_t active,
  output logic commit_pulse,
  output logic mute_left,
  output logic mute_right
);

  typedef struct packed {
    serial_state_t st;
    logic scl;
    logic sda;
    logic [2:0] cnt;
    logic [7:0] shift;
    logic ack_on;
    logic rw;
    logic [7:0] ptr;
    logic oe;
    logic [7:0] ctrl;
    logic [7:0] r_up;
    logic [7:0] r_lo;
    logic [7:0] l_up;
    logic [7:0] l_lo;
    logic [7:0] frame;
    logic [7:0] rj;
    logic [7:0] commit;
    settings_t act;
    logic commit_p;
    logic load_p;
    logic mute_l;
    logic mute_r;
  } top_state_t;

  top_state_t s_q;
  top_state_t s_d;
  logic fill_l;
  logic fill_r;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic [7:0] rd_byte;
  logic [7:0] byte_in;
  logic [DELAY_W-1:0] depth_l;
  logic [DELAY_W-1:0] depth_r;

  // Bus line edges and start/stop conditions
  assign scl_rise = scl && !s_q.scl;
  assign scl_fall = !scl && s_q.scl;
  assign start_c = scl && s_q.scl && s_q.sda && !sda_in;
  assign stop_c = scl && s_q.scl && !s_q.sda && sda_in;
  assign byte_in = {s_q.shift[6:0], sda_in};

  // Read multiplexer, unmapped addresses read zero
  always_comb begin
    unique case (s_q.ptr)
      REG_CONTROL: rd_byte = s_q.ctrl;
      REG_RIGHT_UP: rd_byte = s_q.r_up;
      REG_RIGHT_LO: rd_byte = s_q.r_lo;
      REG_LEFT_UP: rd_byte = s_q.l_up;
      REG_LEFT_LO: rd_byte = s_q.l_lo;
      REG_FRAME: rd_byte = s_q.frame;
      REG_RJ_LEN: rd_byte = s_q.rj;
      REG_COMMIT: rd_byte = s_q.commit;
      default: rd_byte = REG_RESET;
    endcase
  end

  // Fill depth: frame delay replaces the sample delays when selected
  assign depth_l = s_q.act.frame_sel ? frame_delay_samples
                                     : s_q.act.delay_l;
  assign depth_r = s_q.act.frame_sel ? frame_delay_samples
                                     : s_q.act.delay_r;

  // Serial slave, register file and commit transfer
  always_comb begin
    s_d = s_q;
    s_d.scl = scl;
    s_d.sda = sda_in;
    s_d.commit_p = 1'b0;
    s_d.load_p = s_q.commit_p;
    if (start_c) begin
      s_d.st = ST_ADDR;
      s_d.cnt = '0;
      s_d.oe = 1'b0;
    end else if (stop_c) begin
      s_d.st = ST_IDLE;
      s_d.oe = 1'b0;
    end else begin
      unique case (s_q.st)
        ST_IDLE: begin
          s_d.oe = 1'b0;
        end
        ST_ADDR, ST_PTR, ST_WDATA: begin
          if (scl_rise) begin
            s_d.shift = byte_in;
            s_d.cnt = s_q.cnt + 3'h1;
            s_d.ack_on = 1'b0;
            if (s_q.cnt == LAST_BIT) begin
              if (s_q.st == ST_ADDR) begin
                s_d.rw = sda_in;
                s_d.st = (byte_in[7:1] == {DEV_ADDR_HI, addr_sel})
                         ? ST_ADDR_ACK : ST_IDLE;
              end else if (s_q.st == ST_PTR) begin
                s_d.ptr = byte_in;
                s_d.st = ST_PTR_ACK;
              end else begin
                s_d.st = ST_WDATA_ACK;
                unique case (s_q.ptr)
                  REG_CONTROL: s_d.ctrl = byte_in;
                  REG_RIGHT_UP: s_d.r_up = byte_in & DELAY_UPPER_MASK;
                  REG_RIGHT_LO: s_d.r_lo = byte_in;
                  REG_LEFT_UP: s_d.l_up = byte_in & DELAY_UPPER_MASK;
                  REG_LEFT_LO: s_d.l_lo = byte_in;
                  REG_FRAME: s_d.frame = byte_in;
                  REG_RJ_LEN: s_d.rj = byte_in & RJ_LEN_MASK;
                  REG_COMMIT: begin
                    s_d.commit = byte_in;
                    s_d.commit_p = byte_in[COMMIT_BIT];
                  end
                  default: s_d.commit_p = 1'b0;
                endcase
              end
            end
          end
        end
        ST_ADDR_ACK, ST_PTR_ACK, ST_WDATA_ACK: begin
          if (scl_fall) begin
            if (!s_q.ack_on) begin
              s_d.ack_on = 1'b1;
              s_d.oe = 1'b1;
            end else begin
              s_d.ack_on = 1'b0;
              s_d.oe = 1'b0;
              s_d.cnt = '0;
              if (s_q.st == ST_WDATA_ACK) begin
                s_d.ptr = s_q.ptr + 8'h01;
                s_d.st = ST_WDATA;
              end else if (s_q.st == ST_PTR_ACK) begin
                s_d.st = ST_WDATA;
              end else if (s_q.rw) begin
                s_d.shift = rd_byte;
                s_d.oe = !rd_byte[7];
                s_d.st = ST_RD_BIT;
              end else begin
                s_d.st = ST_PTR;
              end
            end
          end
        end
        ST_RD_BIT: begin
          if (scl_rise) begin
            s_d.cnt = s_q.cnt + 3'h1;
            if (s_q.cnt == LAST_BIT) begin
              s_d.st = ST_RD_ACK;
              s_d.ack_on = 1'b0;
            end
          end else if (scl_fall && s_q.cnt != '0) begin
            s_d.shift = {s_q.shift[6:0], 1'b0};
            s_d.oe = !s_q.shift[6];
          end
        end
        ST_RD_ACK: begin
          if (scl_fall && !s_q.ack_on) begin
            s_d.oe = 1'b0;
            s_d.ack_on = 1'b1;
          end else if (scl_rise && s_q.ack_on) begin
            if (sda_in) begin
              s_d.st = ST_IDLE;
            end else begin
              s_d.ptr = s_q.ptr + 8'h01;
            end
          end else if (scl_fall && s_q.ack_on) begin
            s_d.shift = rd_byte;
            s_d.oe = !rd_byte[7];
            s_d.cnt = '0;
            s_d.st = ST_RD_BIT;
          end
        end
      endcase
    end
    // Staged settings move to the datapath as one group
    if (s_q.commit_p) begin
      s_d.act.fmt = s_q.ctrl[1:0];
      s_d.act.frame_sel = s_q.frame[FRAME_SEL_BIT];
      s_d.act.frame = s_q.frame;
      s_d.act.delay_r = {s_q.r_up[4:0], s_q.r_lo};
      s_d.act.delay_l = {s_q.l_up[4:0], s_q.l_lo};
      s_d.act.rj_len = (s_q.rj[5:0] > RJ_LEN_MAX) ? RJ_LEN_MAX
                                                  : s_q.rj[5:0];
    end
    // Mute outputs: control bits directly, or fill in progress
    s_d.mute_l = s_q.ctrl[CTRL_MUTE_LEFT_BIT] || fill_l;
    s_d.mute_r = s_q.ctrl[CTRL_MUTE_RIGHT_BIT] || fill_r;
  end

  // State register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
      s_q.scl <= 1'b1;
      s_q.sda <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Independent fill counters per channel
  fill_mute #(.W(DELAY_W)) u_fill_left (
    .clock(clock),
    .resetn(resetn),
    .load(s_q.load_p),
    .depth(depth_l),
    .sample_tick(sample_tick_left),
    .filling(fill_l)
  );

  fill_mute #(.W(DELAY_W)) u_fill_right (
    .clock(clock),
    .resetn(resetn),
    .load(s_q.load_p),
    .depth(depth_r),
    .sample_tick(sample_tick_right),
    .filling(fill_r)
  );

  // Outputs straight from the state register, except sda_out which is tied low
  assign sda_out = 1'b0; // Open drain: only low is ever driven
  assign sda_oe = s_q.oe;
  assign active = s_q.act;
  assign commit_pulse = s_q.load_p;
  assign mute_left = s_q.mute_l;
  assign mute_right = s_q.mute_r;

endmodule

// >>> testbench/delay_config_commit_chk.sv
`timescale 1ns/1ps
// Assertion checker for the delay settings block
module delay_config_commit_chk
  import delay_config_pkg::*;
(
  // Watched ports
  input wire logic clock,
  input wire logic resetn,
  input wire logic scl,
  input wire logic sda_oe,
  input wire logic sample_tick_left,
  input wire logic sample_tick_right,
  input wire logic [DELAY_W-1:0] frame_delay_samples,
  input delay_config_pkg::settings_t active,
  input wire logic commit_pulse,
  input wire logic mute_left,
  input wire logic mute_right
);
  logic [DELAY_W-1:0] left_q;
  logic [DELAY_W-1:0] right_q;

  // Samples still owed per channel since the last commit
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      left_q <= '0;
      right_q <= '0;
    end else if (commit_pulse) begin
      left_q <= active.frame_sel ? frame_delay_samples : active.delay_l;
      right_q <= active.frame_sel ? frame_delay_samples : active.delay_r;
    end else begin
      if (sample_tick_left && left_q != '0)
        left_q <= left_q - 1'b1;
      if (sample_tick_right && right_q != '0)
        right_q <= right_q - 1'b1;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  AST_PULSE_ONE: assert property (commit_pulse |=> !commit_pulse)
    else $error("commit pulse too long");
  AST_ACTIVE_CHG: assert property (
    active != $past(active) |-> commit_pulse)
    else $error("settings moved without commit");
  AST_RJ_CLAMP: assert property (
    commit_pulse |-> active.rj_len <= RJ_LEN_MAX)
    else $error("packet length not clamped");
  AST_MUTE_RISE: assert property (
    commit_pulse && !active.frame_sel && active.delay_r != '0
    |-> ##[1:4] mute_right)
    else $error("right mute missing after commit");
  AST_FILL_LEFT: assert property (
    left_q != '0 && $past(left_q, 4) != '0 |-> mute_left)
    else $error("left unmuted before fill");
  AST_FILL_RIGHT: assert property (
    right_q != '0 && $past(right_q, 4) != '0 |-> mute_right)
    else $error("right unmuted before fill");
  AST_OE_SCL_LOW: assert property (
    $changed(sda_oe) |-> !scl && !$past(scl))
    else $error("data line moved while clock high");
  AST_RESET_CLEAN: assert property (
    $rose(resetn) |-> !sda_oe && !commit_pulse && !mute_left
    && !mute_right && active == '0)
    else $error("outputs not clear after reset");
endmodule

bind delay_config_commit delay_config_commit_chk delay_config_commit_chk_i (
  .clock(clock), .resetn(resetn), .scl(scl), .sda_oe(sda_oe),
  .sample_tick_left(sample_tick_left),
  .sample_tick_right(sample_tick_right),
  .frame_delay_samples(frame_delay_samples), .active(active),
  .commit_pulse(commit_pulse), .mute_left(mute_left),
  .mute_right(mute_right)
);

// >>> testbench/bus_master_model.sv
`timescale 1ns/1ps
// Two-wire bus master model: clock line and open drain data
module bus_master_model (
  // Clock
  input wire logic clock,
  // Bus
  input wire logic sda,
  output logic scl,
  output logic pull_low
);
  initial begin
    scl = 1'b1;
    pull_low = 1'b0;
  end
  // Wait system clocks
  task automatic hold(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Start or repeated start, clock left low
  task automatic start();
    pull_low <= 1'b0;
    hold(4);
    scl <= 1'b1;
    hold(4);
    pull_low <= 1'b1;
    hold(4);
    scl <= 1'b0;
    hold(4);
  endtask
  // Stop, bus left idle high
  task automatic stop();
    pull_low <= 1'b1;
    hold(4);
    scl <= 1'b1;
    hold(4);
    pull_low <= 1'b0;
    hold(8);
  endtask
  // One bit, b = 1 releases the line, s = level seen
  task automatic xbit(input logic b, output logic s);
    pull_low <= !b;
    hold(4);
    scl <= 1'b1;
    hold(4);
    s = sda;
    hold(4);
    scl <= 1'b0;
    hold(4);
  endtask
  // Byte MSB first plus acknowledge slot
  task automatic byte_io(input logic [7:0] d, input logic ack_in,
                         output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--)
      xbit(d[i], q[i]);
    xbit(ack_in, ack);
  endtask
endmodule

// >>> testbench/delay_config_commit_tb.sv
`timescale 1ns/1ps
// Testbench: register access, commit transfer and fill muting
module delay_config_commit_tb;
  import delay_config_pkg::*;
  logic clock, resetn, tick_l, tick_r;
  logic [2:0] addr_sel;
  logic [DELAY_W-1:0] frame_n;
  wire scl, sda_oe, sda_out, low, cpulse, mute_l, mute_r;
  wire sda = !(sda_oe || low);
  settings_t active, exp_s;
  logic [7:0] wb[8], rb[8];
  int miscompares, total_checks;
  int pulses;
  logic ack_seen;

  // Count commit pulses seen on the datapath side
  always @(posedge clock) begin
    if (cpulse === 1'b1) begin
      pulses <= pulses + 1;
    end
  end

  bus_master_model bus_master_model_i (.clock(clock), .sda(sda),
    .scl(scl), .pull_low(low));
  delay_config_commit delay_config_commit_i (.clock(clock),
    .resetn(resetn), .scl(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .addr_sel(addr_sel), .sample_tick_left(tick_l),
    .sample_tick_right(tick_r), .frame_delay_samples(frame_n),
    .active(active), .commit_pulse(cpulse), .mute_left(mute_l),
    .mute_right(mute_r));

  // Compare at the falling edge, return on a rising edge
  task automatic chk(input string what, input logic [63:0] exp, got);
    @(negedge clock);
    total_checks++;
    if (got !== exp)
      begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
    @(posedge clock);
  endtask
  // Pointer phase, optionally followed by n written bytes
  task automatic wr(input logic [7:0] p, input int n);
    logic [7:0] q;
    logic a;
    bus_master_model_i.start();
    bus_master_model_i.byte_io({DEV_ADDR_HI_DEFAULT, addr_sel, 1'b0},
      1'b1, q, a);
    chk("address ack", 0, a);
    bus_master_model_i.byte_io(p, 1'b1, q, a);
    chk("pointer ack", 0, a);
    for (int i = 0; i < n; i++) begin
      bus_master_model_i.byte_io(wb[i], 1'b1, q, a);
      chk("data ack", 0, a);
    end
  endtask
  // Read n bytes from pointer p into rb
  task automatic rd(input logic [7:0] p, input int n);
    logic a;
    wr(p, 0);
    bus_master_model_i.start();
    bus_master_model_i.byte_io({DEV_ADDR_HI_DEFAULT, addr_sel, 1'b1},
      1'b1, rb[0], a);
    for (int i = 0; i < n; i++)
      bus_master_model_i.byte_io(8'hff, i == n - 1, rb[i], a);
    bus_master_model_i.stop();
  endtask
  // Single byte write with stop
  task automatic wr1(input logic [7:0] p, d);
    wb[0] = d;
    wr(p, 1);
    bus_master_model_i.stop();
  endtask
  // n sample strobes on the chosen channels
  task automatic tick(input logic l, r, input int n);
    repeat (n) begin
      tick_l <= l;
      tick_r <= r;
      @(posedge clock);
      tick_l <= 1'b0;
      tick_r <= 1'b0;
      repeat (3) @(posedge clock);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // Main sequence
  initial begin
    resetn = 1'b0;
    tick_l = 1'b0;
    tick_r = 1'b0;
    addr_sel = 3'h1;
    frame_n = 13'h0004;
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    repeat (2) @(posedge clock);
    rd(REG_CONTROL, 8);
    foreach (rb[i]) chk("reset value", REG_RESET, rb[i]);
    chk("data drive level", 0, sda_out);
    $display("test reset done");
    for (int k = 3; k >= 0; k--) begin
      wr1(REG_CONTROL, {k[1:0], 6'h00});
      chk("mute pair", k[1:0], {mute_r, mute_l});
    end
    chk("no transfer", 0, active);
    $display("test mute done");
    wb = '{8'h01, 8'h00, 8'h03, 8'he0, 8'h05, 8'h00, 8'h3f, 8'hfe};
    wr(REG_CONTROL, 8);
    bus_master_model_i.stop();
    chk("bit zero clear", 0, active);
    wr1(REG_COMMIT, 8'h01);
    exp_s = '{2'b01, 1'b0, 8'h00, 13'h0003, 13'h0005, RJ_LEN_MAX};
    chk("settings", exp_s, active);
    chk("fill mute", 2'b11, {mute_r, mute_l});
    tick(1'b0, 1'b1, 3);
    chk("right filled", 2'b01, {mute_r, mute_l});
    tick(1'b1, 1'b0, 4);
    chk("left filling", 2'b01, {mute_r, mute_l});
    tick(1'b1, 1'b0, 1);
    chk("left filled", 2'b00, {mute_r, mute_l});
    $display("test commit done");
    wr1(REG_FRAME, 8'h85);
    wr1(REG_COMMIT, 8'hfe);
    chk("held frame", 0, active.frame_sel);
    wr1(REG_COMMIT, 8'h01);
    chk("frame select", 1, active.frame_sel);
    exp_s = '{2'b01, 1'b1, 8'h85, 13'h0003, 13'h0005, RJ_LEN_MAX};
    chk("frame settings", exp_s, active);
    tick(1'b1, 1'b1, 3);
    chk("frame filling", 2'b11, {mute_r, mute_l});
    tick(1'b1, 1'b1, 1);
    chk("frame filled", 2'b00, {mute_r, mute_l});
    $display("test frame done");
    bus_master_model_i.start();
    bus_master_model_i.byte_io({DEV_ADDR_HI_DEFAULT, ~addr_sel, 1'b0},
      1'b1, rb[0], ack_seen);
    chk("foreign address ack", 1, ack_seen);
    bus_master_model_i.stop();
    rd(8'h09, 1);
    chk("unmapped read", 0, rb[0]);
    rd(REG_COMMIT, 1);
    chk("commit readback", 8'h01, rb[0]);
    chk("commit pulses", 2, pulses);
    $display("test readback done");
    complete_run();
  end
endmodule
